// [logic/shb_pkg.sv]
// Constants, codes and state types for the serial host and boot port
package shb_pkg;
    // Command byte encodings
    localparam logic [7:0] CMD_WREN  = 8'h06;
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam logic [7:0] CMD_READ  = 8'h03;
    localparam logic [7:0] CMD_RDSR  = 8'h05;
    // Field sizes and last-bit indexes
    localparam int         ADDR_BITS = 16;
    localparam int         PAGE_BITS = 5;
    localparam int         PAGE_LEN  = 32;
    localparam logic [2:0] BIT_FIRST = 3'h0;
    localparam logic [2:0] BIT_LAST  = 3'h7;
    localparam logic [4:0] ADDR_LAST = 5'h0f;
    localparam logic [4:0] HDR_LAST  = 5'h17;
    localparam logic [4:0] BYTE_LAST = 5'h07;
    // Status byte, busy flag in bit 0
    localparam logic [7:0] STAT_BUSY = 8'h01;
    localparam logic [7:0] STAT_IDLE = 8'h00;
    // Page commit time
    localparam int CLK_MHZ    = 200;
    localparam int COMMIT_MS  = 5;
    localparam int COMMIT_CYC = COMMIT_MS * CLK_MHZ * 1000;
    // Strap capture point after reset release
    localparam logic [1:0] STRAP_AT   = 2'h2;
    localparam logic [1:0] STRAP_DONE = 2'h3;
    // Slave and master states
    typedef enum logic [3:0] {
        SL_CMD = 4'h1,
        SL_ADR = 4'h2,
        SL_DAT = 4'h4,
        SL_IGN = 4'h8
    } shb_sl_e;
    typedef enum logic [4:0] {
        MS_IDLE = 5'h01,
        MS_CMD  = 5'h02,
        MS_DAT  = 5'h04,
        MS_END  = 5'h08,
        MS_DONE = 5'h10
    } shb_ms_e;
    // Events passed from link logic to core logic
    typedef enum logic [1:0] {
        EV_WREN = 2'h1,
        EV_PAGE = 2'h2,
        EV_BYTE = 2'h3
    } shb_ev_e;
endpackage : shb_pkg

// [logic/shb_port.sv]
// Serial port: slave to a processor, or, when HAS_NVM is 0, boot master to an external memory
`timescale 1ns/1ps
`default_nettype none
module shb_port
    import shb_pkg::*;
#(
    parameter bit          HAS_NVM       = 1'b1,
    parameter int          NVM_AW        = 11,
    parameter int          COMMIT_CYCLES = COMMIT_CYC,
    parameter int          HALF_DIV      = 8,
    parameter int          BOOT_LEN      = 64,
    parameter logic [15:0] BOOT_START    = 16'h0000
) (
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic        SCLK,
    input  wire logic        CSN_I,
    output var  logic        CSN_O,
    output var  logic        CSN_OE,
    output var  logic        SCLK_O,
    output var  logic        SCLK_OE,
    input  wire logic        MOSI_I,
    output var  logic        MOSI_O,
    output var  logic        MOSI_OE,
    input  wire logic        MISO_I,
    output var  logic        MISO_O,
    output var  logic        MISO_OE,
    input  wire logic        MEMORY_SPACE_SELECT,
    input  wire logic        MODE_MASTER,
    output var  logic [15:0] REG_RADDR,
    input  wire logic [7:0]  REG_RDATA,
    output var  logic        REG_WE,
    output var  logic [15:0] REG_WADDR,
    output var  logic [7:0]  REG_WDATA,
    output var  logic        NVM_BUSY,
    output var  logic        BOOT_WE,
    output var  logic [15:0] BOOT_ADDR,
    output var  logic [7:0]  BOOT_DATA,
    output var  logic        BOOT_DONE
);
    localparam int BW = $clog2(COMMIT_CYCLES + 1);

    logic          master_q;
    logic [1:0]    strap_cnt_q;
    logic [1:0]    strap_q;
    logic [1:0]    sel_q;
    logic [1:0]    miso_q;
    logic [3:0]    csn_q;
    logic [2:0]    ev_q;
    logic [1:0]    part_q;
    logic [15:0]   ra_m_q;
    logic [15:0]   ra_s_q;
    logic [7:0]    rd_word_q;
    shb_sl_e       sl_st_q;
    logic [2:0]    bcnt_q;
    logic [4:0]    acnt_q;
    logic [7:0]    sh_q;
    logic [7:0]    cmd_q;
    logic [15:0]   addr_q;
    logic          ev_tgl_q;
    shb_ev_e       ev_kind_q;
    logic [15:0]   ev_addr_q;
    logic [7:0]    ev_data_q;
    logic          partial_q;
    logic          busy_m_q;
    logic          busy_s_q;
    logic [7:0]    tx_q;
    logic          wren_pend_q;
    logic          wel_q;
    logic          nvm_on_q;
    logic [NVM_AW-PAGE_BITS-1:0] page_base_q;
    logic [BW-1:0] busy_cnt_q;
    logic [7:0]    nvm_q [2**NVM_AW];
    logic [7:0]    page_q [PAGE_LEN];
    shb_ms_e       ms_q;
    logic [7:0]    div_q;
    logic [23:0]   hdr_q;
    logic [4:0]    mcnt_q;
    logic [7:0]    rx_q;
    logic [15:0]   nbyte_q;

    // Slave logic is held in reset while deselected or in master mode
    wire logic       sl_rst_n = ARST_N & ~CSN_I & ~master_q;
    wire logic [7:0] cmd_w    = {sh_q[6:0], MOSI_I};
    wire logic       sl_wr    = (sl_st_q == SL_DAT) && (cmd_q == CMD_WRITE);
    wire logic       sl_rd    = (sl_st_q == SL_DAT) &&
                                (cmd_q == CMD_READ || cmd_q == CMD_RDSR);
    wire logic       ev_go    = ev_q[1] ^ ev_q[2];
    wire logic       csn_rise = csn_q[2] & ~csn_q[3];
    wire logic       sel_s    = sel_q[1] & HAS_NVM;
    wire logic       page_ld  = ev_go && ev_kind_q == EV_PAGE && sel_s && wel_q;
    wire logic       pg_byte  = ev_go && ev_kind_q == EV_BYTE && nvm_on_q;
    wire logic       rg_byte  = ev_go && ev_kind_q == EV_BYTE && !nvm_on_q && !sel_s;
    wire logic       commit   = csn_rise && nvm_on_q && !part_q[1];
    wire logic       tick     = div_q == 8'(HALF_DIV - 1);
    wire logic [7:0] stat_w   = busy_s_q ? STAT_BUSY : STAT_IDLE;

    // Mode strap, caught once a few cycles after reset release
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            strap_cnt_q <= '0;
            master_q    <= 1'b0;
        end else if (strap_cnt_q == STRAP_AT) begin
            master_q    <= strap_q[1] & ~HAS_NVM;
            strap_cnt_q <= STRAP_DONE;
        end else if (strap_cnt_q != STRAP_DONE) begin
            strap_cnt_q <= strap_cnt_q + 2'h1;
        end
    end

    // Synchronisers into the core clock, two stages, three for CSN_I
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            strap_q <= '0;
            sel_q   <= '0;
            miso_q  <= '0;
            csn_q   <= 4'hf;
            ev_q    <= '0;
            part_q  <= '0;
            ra_m_q  <= '0;
            ra_s_q  <= '0;
        end else begin
            strap_q <= {strap_q[0], MODE_MASTER};
            sel_q   <= {sel_q[0], MEMORY_SPACE_SELECT};
            miso_q  <= {miso_q[0], MISO_I};
            csn_q   <= {csn_q[2:0], CSN_I};
            ev_q    <= {ev_q[1:0], ev_tgl_q};
            part_q  <= {part_q[0], partial_q};
            ra_m_q  <= addr_q;
            ra_s_q  <= ra_m_q;
        end
    end

    // Read data; the link loads it only once the address has settled
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            REG_RADDR <= '0;
            rd_word_q <= '0;
        end else begin
            REG_RADDR <= ra_s_q;
            rd_word_q <= sel_s ? nvm_q[REG_RADDR[NVM_AW-1:0]] : REG_RDATA;
        end
    end

    // Slave receive side on rising clock
    always_ff @(posedge SCLK or negedge sl_rst_n) begin
        if (!sl_rst_n) begin
            sl_st_q <= SL_CMD;
            bcnt_q  <= '0;
            acnt_q  <= '0;
            sh_q    <= '0;
            cmd_q   <= '0;
            addr_q  <= '0;
        end else begin
            unique case (sl_st_q)
                SL_CMD: begin
                    sh_q   <= cmd_w;
                    bcnt_q <= bcnt_q + 3'h1;
                    if (bcnt_q == BIT_LAST) begin
                        cmd_q <= cmd_w;
                        if (cmd_w == CMD_WRITE || cmd_w == CMD_READ) begin
                            sl_st_q <= SL_ADR;
                        end else if (cmd_w == CMD_RDSR) begin
                            sl_st_q <= SL_DAT;
                        end else begin
                            sl_st_q <= SL_IGN;
                        end
                    end
                end
                SL_ADR: begin
                    addr_q <= {addr_q[14:0], MOSI_I};
                    acnt_q <= acnt_q + 5'h01;
                    if (acnt_q == ADDR_LAST) begin
                        sl_st_q <= SL_DAT;
                    end
                end
                SL_DAT: begin
                    sh_q   <= cmd_w;
                    bcnt_q <= bcnt_q + 3'h1;
                    if (cmd_q == CMD_READ && bcnt_q == BIT_FIRST) begin
                        addr_q <= addr_q + 16'h0001;
                    end
                    if (sl_wr && bcnt_q == BIT_LAST) begin
                        addr_q <= addr_q + 16'h0001;
                    end
                end
                SL_IGN: begin
                    sl_st_q <= SL_IGN;
                end
            endcase
        end
    end

    // Events to the core; survive deselect, move only inside a frame
    always_ff @(posedge SCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ev_tgl_q  <= 1'b0;
            ev_kind_q <= EV_WREN;
            ev_addr_q <= '0;
            ev_data_q <= '0;
            partial_q <= 1'b0;
        end else if (!CSN_I && !master_q) begin
            if (sl_st_q == SL_CMD) begin
                partial_q <= 1'b0;
            end
            if (sl_st_q == SL_CMD && bcnt_q == BIT_LAST && cmd_w == CMD_WREN) begin
                ev_kind_q <= EV_WREN;
                ev_tgl_q  <= ~ev_tgl_q;
            end
            if (sl_st_q == SL_ADR && acnt_q == ADDR_LAST && cmd_q == CMD_WRITE) begin
                ev_kind_q <= EV_PAGE;
                ev_addr_q <= {addr_q[14:0], MOSI_I};
                ev_tgl_q  <= ~ev_tgl_q;
            end
            if (sl_wr) begin
                partial_q <= bcnt_q != BIT_LAST;
            end
            if (sl_wr && bcnt_q == BIT_LAST) begin
                ev_kind_q <= EV_BYTE;
                ev_addr_q <= addr_q;
                ev_data_q <= cmd_w;
                ev_tgl_q  <= ~ev_tgl_q;
            end
        end
    end

    // Busy flag into the link clock
    always_ff @(posedge SCLK or negedge sl_rst_n) begin
        if (!sl_rst_n) begin
            busy_m_q <= 1'b0;
            busy_s_q <= 1'b0;
        end else begin
            busy_m_q <= NVM_BUSY;
            busy_s_q <= busy_m_q;
        end
    end

    // Slave transmit side on falling clock
    always_ff @(negedge SCLK or negedge sl_rst_n) begin
        if (!sl_rst_n) begin
            MISO_O  <= 1'b0;
            MISO_OE <= 1'b0;
            tx_q    <= '0;
        end else if (sl_rd) begin
            MISO_OE <= 1'b1;
            if (bcnt_q == BIT_FIRST) begin
                if (cmd_q == CMD_RDSR) begin
                    tx_q   <= {stat_w[6:0], 1'b0};
                    MISO_O <= stat_w[7];
                end else begin
                    tx_q   <= {rd_word_q[6:0], 1'b0};
                    MISO_O <= rd_word_q[7];
                end
            end else begin
                tx_q   <= {tx_q[6:0], 1'b0};
                MISO_O <= tx_q[7];
            end
        end
    end

    // Write enable latch, page write control and commit timer
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wren_pend_q <= 1'b0;
            wel_q       <= 1'b0;
            nvm_on_q    <= 1'b0;
            page_base_q <= '0;
            busy_cnt_q  <= '0;
            NVM_BUSY    <= 1'b0;
            REG_WE      <= 1'b0;
            REG_WADDR   <= '0;
            REG_WDATA   <= '0;
        end else begin
            REG_WE <= rg_byte;
            if (rg_byte) begin
                REG_WADDR <= ev_addr_q;
                REG_WDATA <= ev_data_q;
            end
            if (ev_go && ev_kind_q == EV_WREN && HAS_NVM) begin
                wren_pend_q <= 1'b1;
            end else if (ev_go) begin
                wren_pend_q <= 1'b0;
            end
            if (page_ld) begin
                nvm_on_q    <= 1'b1;
                page_base_q <= ev_addr_q[NVM_AW-1:PAGE_BITS];
            end
            if (csn_rise) begin
                nvm_on_q <= 1'b0;
                if (wren_pend_q) begin
                    wel_q       <= 1'b1;
                    wren_pend_q <= 1'b0;
                end else if (nvm_on_q) begin
                    wel_q <= 1'b0;
                end
            end
            if (commit) begin
                NVM_BUSY   <= 1'b1;
                busy_cnt_q <= BW'(COMMIT_CYCLES - 1);
            end else if (busy_cnt_q != '0) begin
                busy_cnt_q <= busy_cnt_q - 1'b1;
            end else begin
                NVM_BUSY <= 1'b0;
            end
        end
    end

    // Page buffer and memory array
    always_ff @(posedge CLK) begin
        if (page_ld) begin
            for (int i = 0; i < PAGE_LEN; i++) begin
                page_q[i] <= nvm_q[{ev_addr_q[NVM_AW-1:PAGE_BITS], PAGE_BITS'(i)}];
            end
        end
        if (pg_byte) begin
            page_q[ev_addr_q[PAGE_BITS-1:0]] <= ev_data_q;
        end
        if (commit) begin
            for (int i = 0; i < PAGE_LEN; i++) begin
                nvm_q[{page_base_q, PAGE_BITS'(i)}] <= page_q[i];
            end
        end
    end

    // Boot master: read command, address, then sequential bytes
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ms_q      <= MS_IDLE;
            div_q     <= '0;
            hdr_q     <= '0;
            mcnt_q    <= '0;
            rx_q      <= '0;
            nbyte_q   <= '0;
            CSN_O     <= 1'b1;
            CSN_OE    <= 1'b0;
            SCLK_O    <= 1'b0;
            SCLK_OE   <= 1'b0;
            MOSI_O    <= 1'b0;
            MOSI_OE   <= 1'b0;
            BOOT_WE   <= 1'b0;
            BOOT_ADDR <= '0;
            BOOT_DATA <= '0;
            BOOT_DONE <= 1'b0;
        end else begin
            BOOT_WE <= 1'b0;
            div_q   <= tick ? 8'h00 : div_q + 8'h01;
            unique case (ms_q)
                MS_IDLE: begin
                    if (master_q) begin
                        CSN_O   <= 1'b0;
                        CSN_OE  <= 1'b1;
                        SCLK_OE <= 1'b1;
                        MOSI_OE <= 1'b1;
                        hdr_q   <= {CMD_READ, BOOT_START};
                        MOSI_O  <= CMD_READ[7];
                        div_q   <= 8'h00;
                        ms_q    <= MS_CMD;
                    end
                end
                MS_CMD: begin
                    if (tick) begin
                        SCLK_O <= ~SCLK_O;
                        if (!SCLK_O) begin
                            mcnt_q <= mcnt_q + 5'h01;
                            if (mcnt_q == HDR_LAST) begin
                                mcnt_q <= '0;
                                ms_q   <= MS_DAT;
                            end
                        end else begin
                            hdr_q  <= {hdr_q[22:0], 1'b0};
                            MOSI_O <= hdr_q[22];
                        end
                    end
                end
                MS_DAT: begin
                    if (tick) begin
                        SCLK_O <= ~SCLK_O;
                        if (!SCLK_O) begin
                            rx_q   <= {rx_q[6:0], miso_q[1]};
                            mcnt_q <= (mcnt_q == BYTE_LAST) ? 5'h00 : mcnt_q + 5'h01;
                            if (mcnt_q == BYTE_LAST) begin
                                BOOT_WE   <= 1'b1;
                                BOOT_DATA <= {rx_q[6:0], miso_q[1]};
                                BOOT_ADDR <= nbyte_q;
                                nbyte_q   <= nbyte_q + 16'h0001;
                                if (nbyte_q == 16'(BOOT_LEN - 1)) begin
                                    ms_q <= MS_END;
                                end
                            end
                        end
                    end
                end
                MS_END: begin
                    if (tick) begin
                        SCLK_O    <= 1'b0;
                        CSN_O     <= 1'b1;
                        BOOT_DONE <= 1'b1;
                        ms_q      <= MS_DONE;
                    end
                end
                MS_DONE: begin
                    ms_q <= MS_DONE;
                end
            endcase
        end
    end

    // Checks
    a_miso_deselect: assert property (
        @(posedge CLK) disable iff (!ARST_N) CSN_I |=> !MISO_OE)
        else $error("MISO driven while deselected");
    a_unknown_quiet: assert property (
        @(negedge SCLK) disable iff (!sl_rst_n) (sl_st_q == SL_IGN) |-> !MISO_OE)
        else $error("MISO driven after ignored command");
    a_reg_space: assert property (
        @(posedge CLK) disable iff (!ARST_N) REG_WE |-> !$past(sel_s))
        else $error("Register write while memory space selected");
    a_commit_busy: assert property (
        @(posedge CLK) disable iff (!ARST_N) commit |=> NVM_BUSY [*8])
        else $error("Busy not held after commit");
    a_commit_wel: assert property (
        @(posedge CLK) disable iff (!ARST_N) commit |-> wel_q && HAS_NVM)
        else $error("Page commit without write enable latch");
    a_abort_drop: assert property (
        @(posedge CLK) disable iff (!ARST_N) (csn_rise && part_q[1]) |-> !commit)
        else $error("Aborted memory write committed");
    a_master_select: assert property (
        @(posedge CLK) disable iff (!ARST_N) (ms_q == MS_DAT) |-> !CSN_O && CSN_OE)
        else $error("Select high during boot read");
    a_boot_end: assert property (
        @(posedge CLK) disable iff (!ARST_N) $rose(BOOT_DONE) |-> CSN_O && !SCLK_O)
        else $error("Boot ended without deselect");
    a_master_slave: assert property (
        @(posedge CLK) disable iff (!ARST_N) master_q |=> !MISO_OE && !HAS_NVM)
        else $error("Slave active in master mode");
endmodule : shb_port
`default_nettype wire

// [sim/shb_boot_mem.sv]
// Behavioural external serial boot memory answering read frames
`timescale 1ns/1ps
`default_nettype none
module shb_boot_mem (
    input  wire logic        CSN,
    input  wire logic        SCLK,
    input  wire logic        MOSI,
    output var  logic        MISO,
    output var  logic [23:0] HDR
);
    int         cnt;
    logic [7:0] byte_q;
    initial MISO = 1'b0;
    // Header capture and bit count on rising clock
    always @(posedge SCLK or posedge CSN) begin
        if (CSN) begin
            cnt <= 0;
        end else begin
            if (cnt < 24) HDR <= {HDR[22:0], MOSI};
            cnt <= cnt + 1;
        end
    end
    // Data out on falling clock; released line shows no stale level
    always @(negedge SCLK or posedge CSN) begin
        if (CSN) begin
            MISO <= ~MISO;
        end else if (cnt >= 24) begin
            byte_q = 8'((cnt - 24) / 8 * 29 + 55);
            MISO <= byte_q[7 - (cnt - 24) % 8];
        end
    end
endmodule // shb_boot_mem
`default_nettype wire

// [sim/shb_tb_top.sv]
// Self-checking bench for the serial host port and its boot master
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin \
    $display("BAD %s exp %h got %h", nm, e, s); error_cnt++; end end
module spi_host_and_boot_port_tb_top;
    import shb_pkg::*;
    logic        CLK, ARST_N, SCLK, CSN_I, MOSI_I, SEL, strap, s_csn_oe, b_csn_oe;
    logic        miso, miso_oe, we, busy, bwe, bdone, b_csn, b_sclk, b_mosi, b_miso;
    logic [15:0] raddr, waddr, baddr, a;
    logic [7:0]  wdata, bdata, rdata;
    logic [23:0] hdr, e24;
    logic [7:0]  rq[$], wq[$];
    logic [23:0] regq[$];
    logic [7:0]  nvm[int];
    int          error_cnt, n_compared, seed, nboot, n;
    function automatic logic [7:0] reg_val(input logic [15:0] x);
        return x[7:0] ^ x[15:8] ^ 8'h5c;
    endfunction
    assign rdata = reg_val(raddr);
    shb_port #(.COMMIT_CYCLES(400)) shb_port_i (.CLK(CLK), .ARST_N(ARST_N), .SCLK(SCLK),
        .CSN_I(CSN_I), .CSN_O(), .CSN_OE(s_csn_oe), .SCLK_O(), .SCLK_OE(), .MOSI_I(MOSI_I),
        .MOSI_O(), .MOSI_OE(), .MISO_I(b_miso), .MISO_O(miso), .MISO_OE(miso_oe),
        .MEMORY_SPACE_SELECT(SEL), .MODE_MASTER(strap), .REG_RADDR(raddr), .REG_RDATA(rdata),
        .REG_WE(we), .REG_WADDR(waddr),
        .REG_WDATA(wdata), .NVM_BUSY(busy), .BOOT_WE(), .BOOT_ADDR(), .BOOT_DATA(), .BOOT_DONE());
    shb_port #(.HAS_NVM(1'b0), .BOOT_LEN(4)) shb_port_b_i (.CLK(CLK), .ARST_N(ARST_N),
        .SCLK(SCLK), .CSN_I(CSN_I), .CSN_O(b_csn), .CSN_OE(b_csn_oe), .SCLK_O(b_sclk),
        .SCLK_OE(), .MOSI_I(MOSI_I), .MOSI_O(b_mosi), .MOSI_OE(), .MISO_I(b_miso), .MISO_O(),
        .MISO_OE(), .MEMORY_SPACE_SELECT(SEL), .MODE_MASTER(strap), .REG_RADDR(), .REG_RDATA(rdata),
        .REG_WE(), .REG_WADDR(), .REG_WDATA(), .NVM_BUSY(), .BOOT_WE(bwe), .BOOT_ADDR(baddr),
        .BOOT_DATA(bdata), .BOOT_DONE(bdone));
    shb_boot_mem shb_boot_mem_i (.CSN(b_csn), .SCLK(b_sclk), .MOSI(b_mosi), .MISO(b_miso),
        .HDR(hdr));
    // Core clock
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    // Register writes and boot bytes against the expected model
    always @(negedge CLK) begin
        if (we) begin
            e24 = regq.size() ? regq.pop_front() : 24'hxxxxxx;
            `CHK("reg_write", e24, {waddr, wdata})
        end
        if (bwe) begin
            `CHK("boot_addr", 16'(nboot), baddr)
            `CHK("boot_data", 8'(nboot * 29 + 55), bdata)
            nboot++;
        end
    end
    // One link bit, sampled by both sides at the rising edge
    task automatic sbit(input logic b, input logic oe, output logic r);
        MOSI_I = oe ? 1'bz : b;
        #32 SCLK = 1'b1;
        r = miso;
        `CHK("miso_oe", oe, miso_oe)
        #32 SCLK = 1'b0;
    endtask
    task automatic sbyte(input logic [7:0] t, input logic oe, input int nb, output logic [7:0] r);
        for (int i = 7; i > 7 - nb; i--) sbit(t[i], oe, r[i]);
    endtask
    // Whole frame: idle clocking, command, address, bytes, optional partial byte
    task automatic frame(input logic [7:0] c, input logic [15:0] ad, input int nb, input int part);
        logic [7:0] r;
        logic       rd;
        rd = (c == CMD_READ) || (c == CMD_RDSR);
        rq = {};
        repeat (4) begin
            #32 SCLK = ~SCLK;
            MOSI_I = 1'($random(seed));
        end
        CSN_I = 1'b0;
        #32 sbyte(c, 1'b0, 8, r);
        if (c != CMD_WREN && c != CMD_RDSR) begin
            sbyte(ad[15:8], 1'b0, 8, r);
            sbyte(ad[7:0], 1'b0, 8, r);
        end
        for (int i = 0; i < nb; i++) begin
            sbyte(rd ? 8'h00 : wq[i], rd, 8, r);
            rq.push_back(r);
        end
        if (part > 0) sbyte(8'h5a, 1'b0, part, r);
        #20 CSN_I = 1'b1;
        #10 `CHK("miso_oe_off", 1'b0, miso_oe)
        #100;
    endtask
    task automatic final_report;
        if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Watchdog
    initial begin
        #400us;
        error_cnt++;
        final_report;
    end
    // Main sequence
    initial begin
        seed = 32'h027a;
        {ARST_N, SCLK, MOSI_I, SEL, error_cnt, n_compared, nboot} = '0;
        CSN_I = 1'b1;
        strap = 1'b1;
        repeat (20) @(negedge CLK);
        ARST_N = 1'b1;
        repeat (8) @(negedge CLK);
        // Register read across an address byte carry
        frame(CMD_READ, 16'h12fe, 3, 0);
        for (int i = 0; i < 3; i++) `CHK("reg_read", reg_val(16'h12fe + 16'(i)), rq[i])
        // Register writes aborted after 1, 4 and 7 bits of a third byte
        for (int k = 0; k < 3; k++) begin
            a = 16'($random(seed));
            wq = {8'($random(seed)), 8'($random(seed))};
            for (int i = 0; i < 2; i++) regq.push_back({a + 16'(i), wq[i]});
            frame(CMD_WRITE, a, 2, k * 3 + 1);
        end
        // Unknown and write enable commands leave the port silent
        frame(8'ha5, 16'h0001, 2, 0);
        frame(8'h04, 16'h0002, 2, 0);
        frame(CMD_WREN, 16'h0000, 0, 0);
        `CHK("reg_pending", 0, regq.size())
        // Memory page writes: full, aborted mid-byte, without write enable
        SEL = 1'b1;
        for (int k = 0; k < 3; k++) begin
            wq = {};
            repeat (6) wq.push_back(8'($random(seed)));
            if (k != 2) frame(CMD_WREN, 16'h0000, 0, 0);
            frame(CMD_WRITE, 16'h003c, 6, k == 1 ? 3 : 0);
            `CHK("nvm_busy", k == 0, busy)
            if (k == 0) for (int i = 0; i < 6; i++) nvm[32 + (28 + i) % 32] = wq[i];
            frame(CMD_RDSR, 16'h0000, 1, 0);
            `CHK("status_first", k == 0 ? STAT_BUSY : STAT_IDLE, rq[0])
            n = 0;
            do begin
                frame(CMD_RDSR, 16'h0000, 1, 0);
                n++;
            end while (rq[0][0] !== 1'b0 && n < 10);
            `CHK("status_last", STAT_IDLE, rq[0])
            frame(CMD_READ, 16'h0020, 32, 0);
            foreach (nvm[j]) `CHK("nvm_read", nvm[j], rq[j - 32])
        end
        // Boot master outcome
        for (int i = 0; i < 4000 && bdone !== 1'b1; i++) @(negedge CLK);
        `CHK("boot_done", 1'b1, bdone)
        `CHK("boot_count", 4, nboot)
        `CHK("boot_header", {CMD_READ, 16'h0000}, hdr)
        `CHK("boot_csn", 1'b1, b_csn)
        `CHK("boot_csn_oe", 1'b1, b_csn_oe)
        `CHK("slave_csn_oe", 1'b0, s_csn_oe)
        final_report;
    end
endmodule // spi_host_and_boot_port_tb_top
`default_nettype wire
